/* File: rtl/sem_host_map.svh */
`ifndef SEM_HOST_MAP_SVH
`define SEM_HOST_MAP_SVH

// Number of flags and width of the flag index.
`define SEM_FLAG_COUNT 8
`define SEM_IDX_W 3
// Port address and data widths.
`define SEM_ADDR_W 12
`define SEM_DATA_W 16
// Strobe timing: setup, pulse and recovery lengths in ns.
`define SEM_CLK_NS 10
`define SEM_SETUP_NS 20
`define SEM_PULSE_NS 40
`define SEM_RECOVER_NS 20
`define SEM_SETUP_CYC ((`SEM_SETUP_NS + `SEM_CLK_NS - 1) / `SEM_CLK_NS)
`define SEM_PULSE_CYC ((`SEM_PULSE_NS + `SEM_CLK_NS - 1) / `SEM_CLK_NS)
`define SEM_RECOVER_CYC ((`SEM_RECOVER_NS + `SEM_CLK_NS - 1) / `SEM_CLK_NS)
// Command codes.
`define SEM_CMD_ACQUIRE 2'h0
`define SEM_CMD_RELEASE 2'h1
`define SEM_CMD_POLL 2'h2
`define SEM_CMD_INIT 2'h3

`endif

/* File: rtl/sem_host_pkg.sv */
package sem_host_pkg;

  // Command word handed in by the user logic.
  typedef struct packed {
    logic [1:0] op;
    logic [2:0] idx;
  } cmd_s;

  // Result handed back to the user logic.
  typedef struct packed {
    logic owned;
    logic [2:0] idx;
  } result_s;

  // Pin-level controls driven toward one device port.
  typedef struct packed {
    logic mem_select_n;
    logic flag_space_select_n;
    logic out_enable_n;
    logic write_n;
  } ctrl_s;

endpackage

/* File: rtl/sem_host.sv */
`timescale 1ns/100ps
`include "sem_host_map.svh"

// Overview of operation
// - Flags are active low; write zero to request, one to release.
// - Host drives flag select low with normal address, enable, write strobes.
// - Host deasserts select or output enable between successive reads.
// - Host writes zero first, then reads to confirm ownership.
// - After failure host keeps reading or writes one to withdraw.
// - Startup writes one to every flag so all begin free.
// - Memory chip select stays high during every flag access.
module sem_host #(
  parameter int ADDR_W = `SEM_ADDR_W,
  parameter int DATA_W = `SEM_DATA_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input sem_host_pkg::cmd_s cmd,
  output logic cmd_ready,
  output logic done,
  output sem_host_pkg::result_s result,
  output logic init_done,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_in,
  output sem_host_pkg::ctrl_s ctrl
);

  typedef enum logic [2:0] {
    S_RESET, S_IDLE, S_SETUP, S_PULSE, S_RECOVER
  } state_e;

  localparam logic [3:0] SETUP_CYC = 4'(`SEM_SETUP_CYC);
  localparam logic [3:0] PULSE_CYC = 4'(`SEM_PULSE_CYC);
  localparam logic [3:0] RECOVER_CYC = 4'(`SEM_RECOVER_CYC);

  state_e state;
  state_e next_state;
  logic [3:0] count;
  logic is_read;
  logic wr_bit;
  logic [1:0] op;
  logic [2:0] idx;
  logic init_side;
  logic [DATA_W-1:0] din_meta;
  logic [DATA_W-1:0] din_sync;

  // Decoded conditions of the sequencer.
  wire count_done = (count == 4'h0);
  // A command is taken only while ready is shown, so none slips in early.
  wire take_cmd = (state == S_IDLE) && cmd_valid && cmd_ready;
  wire acquire_cmd = (cmd.op == `SEM_CMD_ACQUIRE);
  wire poll_cmd = (cmd.op == `SEM_CMD_POLL);
  wire release_cmd = (cmd.op == `SEM_CMD_RELEASE);
  wire need_read = (op == `SEM_CMD_ACQUIRE) && !is_read;
  wire init_last = (idx == 3'h7);
  wire flag_low = (din_sync[0] == 1'b0);

  // The data bus passes two flip-flops before the sample is used.
  always_ff @(posedge clk) begin
    din_meta <= data_in;
    din_sync <= din_meta;
  end

  // Next state of the access sequencer.
  always_comb begin
    next_state = state;
    case (state)
      S_RESET: next_state = S_SETUP;
      S_IDLE: begin
        if (take_cmd) begin
          next_state = S_SETUP;
        end
      end
      S_SETUP: begin
        if (count_done) begin
          next_state = S_PULSE;
        end
      end
      S_PULSE: begin
        if (count_done) begin
          next_state = S_RECOVER;
        end
      end
      S_RECOVER: begin
        if (!count_done) begin
          next_state = S_RECOVER;
        end else if (need_read) begin
          next_state = S_SETUP;
        end else if (!init_done && !(init_last && init_side)) begin
          next_state = S_SETUP;
        end else begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_RESET;
    endcase
  end

  // Cycle counter for setup, pulse and recovery phases.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= 4'h0;
    end else if (next_state == S_SETUP && state != S_SETUP) begin
      count <= SETUP_CYC - 4'h1;
    end else if (next_state == S_PULSE && state != S_PULSE) begin
      count <= PULSE_CYC - 4'h1;
    end else if (next_state == S_RECOVER && state != S_RECOVER) begin
      count <= RECOVER_CYC - 4'h1;
    end else if (!count_done) begin
      count <= count - 4'h1;
    end
  end

  // Command capture, init walk over all flags and result reporting.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= S_RESET;
      op <= `SEM_CMD_INIT;
      idx <= 3'h0;
      is_read <= 1'b0;
      wr_bit <= 1'b1;
      init_side <= 1'b0;
      init_done <= 1'b0;
      done <= 1'b0;
      result <= '0;
    end else begin
      state <= next_state;
      done <= 1'b0;
      if (take_cmd) begin
        op <= cmd.op;
        idx <= cmd.idx;
        is_read <= poll_cmd;
        wr_bit <= release_cmd || !acquire_cmd;
      end
      if (state == S_RECOVER && count_done) begin
        if (need_read) begin
          is_read <= 1'b1;
        end else if (!init_done) begin
          // Each flag is released twice so a stale request is cleared too.
          init_side <= !init_side;
          if (init_side) begin
            idx <= idx + 3'h1;
          end
          if (init_last && init_side) begin
            init_done <= 1'b1;
          end
        end else begin
          done <= 1'b1;
          result.idx <= idx;
          result.owned <= is_read && flag_low;
        end
      end
    end
  end

  // Pin drive; selects and strobes are registered.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= '{1'b1, 1'b1, 1'b1, 1'b1};
      addr <= '0;
      data_out <= '1;
      data_oe <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      cmd_ready <= (next_state == S_IDLE) && init_done && !take_cmd;
      ctrl.mem_select_n <= 1'b1;
      ctrl.flag_space_select_n <= !(next_state == S_SETUP ||
        next_state == S_PULSE);
      ctrl.out_enable_n <= !(is_read && next_state == S_PULSE);
      ctrl.write_n <= !(!is_read && next_state == S_PULSE);
      addr <= {{(ADDR_W-3){1'b0}}, idx};
      data_out <= {{(DATA_W-1){1'b1}}, wr_bit};
      data_oe <= !is_read && (next_state == S_SETUP ||
        next_state == S_PULSE);
    end
  end

endmodule // sem_host

/* File: test/sem_host_properties.sv */
`timescale 1ns/100ps
module sem_host_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input sem_host_pkg::cmd_s cmd,
  input wire logic cmd_ready,
  input wire logic done,
  input wire logic [11:0] addr,
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  input sem_host_pkg::ctrl_s ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // A command is taken when valid meets ready.
  wire take = cmd_valid && cmd_ready;
  sequence s_pulse;
    !ctrl.write_n [*4] ##1 ctrl.write_n;
  endsequence
  property p_cs; ctrl.mem_select_n; endproperty
  a_cs: assert property (p_cs) else $error("array select low");
  property p_hi; !ctrl.flag_space_select_n |-> addr[11:3] == 9'h0; endproperty
  a_hi: assert property (p_hi) else $error("high address set");
  property p_wr; !ctrl.write_n |-> !ctrl.flag_space_select_n && data_oe;
  endproperty
  a_wr: assert property (p_wr) else $error("write unselected");
  property p_d0; data_oe |-> &data_out[15:1]; endproperty
  a_d0: assert property (p_d0) else $error("upper data bits");
  property p_pulse; $fell(ctrl.write_n) |-> s_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length");
  property p_rd; !ctrl.out_enable_n |-> !ctrl.flag_space_select_n && !data_oe;
  endproperty
  a_rd: assert property (p_rd) else $error("read unselected");
  property p_gap; $rose(ctrl.out_enable_n) |-> ctrl.flag_space_select_n;
  endproperty
  a_gap: assert property (p_gap) else $error("select held");
  property p_rel; take && cmd.op == 2'h1 |-> ##[8:10] done; endproperty
  a_rel: assert property (p_rel) else $error("release late");
  property p_acq; take && cmd.op == 2'h0 |-> ##[2:4] !ctrl.write_n;
  endproperty
  a_acq: assert property (p_acq) else $error("acquire no write");
endmodule // sem_host_properties

/* File: test/sem_flag_model.sv */
`timescale 1ns/100ps
module sem_flag_model (
  input wire logic [11:0] addr,
  input wire logic [15:0] data_out,
  input sem_host_pkg::ctrl_s ctrl,
  output logic [15:0] data_in
);
  logic [7:0] req_l;
  logic [7:0] req_r;
  logic [1:0] own [8];
  logic rd;
  wire rd_n = ctrl.flag_space_select_n | ctrl.out_enable_n;
  // Owner 1 is this port, 2 the far port; x or 0 means free.
  task automatic settle(input int i);
    logic f;
    f = own[i][0] === own[i][1];
    if (req_l[i] === 1'b1 && req_r[i] === 1'b1) own[i] = 2'h0;
    else if (f && req_l[i] === 1'b0) own[i] = 2'h1;
    else if (f && req_r[i] === 1'b0) own[i] = 2'h2;
    else if (own[i] == 2'h1 && req_l[i]) own[i] = 2'h2;
    else if (own[i] == 2'h2 && req_r[i]) own[i] = 2'h1;
  endtask
  task automatic right_write(input int i, input logic b);
    req_r[i] = b;
    settle(i);
  endtask
  function automatic logic right_view(input int i);
    return own[i] !== 2'h2;
  endfunction
  // Write strobe takes bit zero of the selected flag.
  always @(negedge ctrl.write_n) begin
    if (!ctrl.flag_space_select_n && ctrl.mem_select_n) begin
      req_l[addr[2:0]] = data_out[0];
      settle(addr[2:0]);
    end
  end
  // Read value is held from select and enable onward.
  always @(negedge rd_n) rd = own[addr[2:0]] !== 2'h1;
  assign data_in = rd_n ? ~{16{rd}} : {16{rd}};
endmodule // sem_flag_model

/* File: test/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  sem_host_pkg::cmd_s cmd = '0;
  logic cmd_ready, done, init_done, data_oe;
  sem_host_pkg::result_s result;
  sem_host_pkg::ctrl_s ctrl;
  logic [11:0] addr;
  logic [15:0] data_out, data_in;
  int failures = 0;
  int samples_checked = 0;
  // Free-running clock.
  always #5 clk = ~clk;
  sem_host i_dut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .done(done), .result(result),
    .init_done(init_done), .addr(addr), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in), .ctrl(ctrl));
  sem_flag_model i_dev (.addr(addr), .data_out(data_out), .ctrl(ctrl),
    .data_in(data_in));
  task print_verdict;
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task check(input logic [3:0] exp, input logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_for(input int k);
    for (int n = 0; (k == 0 ? cmd_ready : k == 1 ? done : init_done) !== 1'b1;
         n++) begin
      if (n > 400) begin
        failures++;
        $display("ERROR %0t wait timed out", $time);
        print_verdict();
      end
      @(negedge clk);
    end
  endtask
  task automatic run(input logic [1:0] op, input logic [2:0] i);
    wait_for(0);
    cmd_valid = 1'b1;
    cmd = '{op, i};
    @(negedge clk);
    cmd_valid = 1'b0;
    wait_for(1);
  endtask
  // Token handover between the two ports on one flag.
  task sc_own;
    run(2'h0, 3'h3); check(4'hB, result);
    i_dev.right_write(3, 1'b0);
    check(4'h1, {3'h0, i_dev.right_view(3)});
    run(2'h1, 3'h3); check(4'h0, {3'h0, i_dev.right_view(3)});
    run(2'h0, 3'h3); check(4'h3, result);
    run(2'h3, 3'h3);
    i_dev.right_write(3, 1'b1);
    run(2'h2, 3'h3); check(4'h3, result);
  endtask
  // Every flag acquired, polled, released and polled free.
  task sc_all;
    for (int i = 0; i < 8; i++) begin
      run(2'h0, i[2:0]); check({1'b1, i[2:0]}, result);
      run(2'h2, i[2:0]); check({1'b1, i[2:0]}, result);
      run(2'h1, i[2:0]);
      run(2'h2, i[2:0]); check({1'b0, i[2:0]}, result);
    end
  endtask
  // Far port starts free, reset, then the scenarios.
  initial begin
    for (int i = 0; i < 8; i++) i_dev.right_write(i, 1'b1);
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    wait_for(2);
    sc_own();
    sc_all();
    print_verdict();
  end
endmodule // tb_top
bind sem_host sem_host_properties i_props (.clk(clk), .sys_rst(sys_rst),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .done(done),
  .addr(addr), .data_out(data_out), .data_oe(data_oe), .ctrl(ctrl));
